// file: src/chopper_pkg.sv
`default_nettype none
package chopper_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_MHZ          = 125;
  localparam int T_OFF_7_NS       = 7000;
  localparam int T_OFF_16_NS      = 16000;
  localparam int T_OFF_24_NS      = 24000;
  localparam int T_OFF_32_NS      = 32000;
  localparam int T_BLANK_NS       = 1000;
  localparam int T_DEGLITCH_NS    = 10000;
  localparam logic [11:0] OFF_7_CYC  = 12'((T_OFF_7_NS * CLK_MHZ) / 1000);
  localparam logic [11:0] OFF_16_CYC = 12'((T_OFF_16_NS * CLK_MHZ) / 1000);
  localparam logic [11:0] OFF_24_CYC = 12'((T_OFF_24_NS * CLK_MHZ) / 1000);
  localparam logic [11:0] OFF_32_CYC = 12'((T_OFF_32_NS * CLK_MHZ) / 1000);
  localparam logic [11:0] BLANK_CYC  =
    12'((T_BLANK_NS * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] DEGLITCH_CYC =
    12'((T_DEGLITCH_NS * CLK_MHZ) / 1000);

  // ==========================================================
  // Multi-level pin codes from the analog front end
  localparam logic [1:0] LVL_LOW  = 2'h0;
  localparam logic [1:0] LVL_HIGH = 2'h1;
  localparam logic [1:0] LVL_OPEN = 2'h2;
  localparam logic [1:0] LVL_RES  = 2'h3;

  // ==========================================================
  // Mixed decay shares
  localparam logic [15:0] MIX30_NUM = 16'h0003;
  localparam logic [15:0] MIX60_NUM = 16'h0006;
  localparam logic [15:0] MIX_DEN   = 16'h000A;
  localparam logic [3:0]  SHARE_MAX = 4'h8;

  // ==========================================================
  // Gate patterns {hs_a, ls_a, hs_b, ls_b}
  localparam logic [3:0] GATES_OFF  = 4'h0;
  localparam logic [3:0] GATES_SLOW = 4'h5;
  localparam logic [3:0] GATES_FWD  = 4'h9;
  localparam logic [3:0] GATES_REV  = 4'h6;

  // ==========================================================
  // Register map
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [1:0] CTRL_RESET  = 2'h1;
  localparam int         CTRL_RUN    = 0;
  localparam int         CTRL_FULL   = 1;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_BLANK = 3'h1,
    ST_DRIVE = 3'h2,
    ST_FAST  = 3'h3,
    ST_SLOW  = 3'h4
  } fsm_t;

  typedef enum logic [2:0] {
    DM_DYNAMIC  = 3'h0,
    DM_RIPPLE   = 3'h1,
    DM_MIX30    = 3'h2,
    DM_SLOWMIX  = 3'h3,
    DM_MIX60    = 3'h4,
    DM_SLOW     = 3'h5
  } decay_mode_t;

endpackage
`default_nettype wire

// file: src/config_deglitch.sv
`timescale 1ns/1ns
`default_nettype none
module config_deglitch
  import chopper_pkg::*;
#(
  parameter int W = 2
)
(
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] sample,
  output logic      [W-1:0] stable
);

  typedef struct packed {
    logic [W-1:0] cand;
    logic [11:0]  cnt;
    logic [W-1:0] out;
  } dg_t;

  dg_t r_reg;
  dg_t r_next;

  // ==========================================================
  // Adopt a new level only after it held for the full window
  always_comb
  begin
    r_next = r_reg;
    if (sample != r_reg.cand)
    begin
      r_next.cand = sample;
      r_next.cnt  = 12'h000;
    end
    else if (r_reg.out != r_reg.cand)
    begin
      if (r_reg.cnt == DEGLITCH_CYC - 12'h001)
        r_next.out = r_reg.cand;
      else
        r_next.cnt = r_reg.cnt + 12'h001;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  assign stable = r_reg.out;

  // ==========================================================
  // Checks
  AST_DEGLITCH_WAIT: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $changed(r_reg.out) |->
      $past(r_reg.cnt) == DEGLITCH_CYC - 12'h001 &&
      $past(sample, 2) == r_reg.out)
    else $error("config changed before deglitch window");

endmodule // config_deglitch
`default_nettype wire

// file: src/chopper_decay_control.sv
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module chopper_decay_control
  import chopper_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        sleep_control_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  decay_select_low,
  input  wire logic [1:0]  decay_select_high,
  input  wire logic [1:0]  off_time_select,
  input  wire logic [1:0]  microstep_select_0,
  input  wire logic [1:0]  microstep_select_1,
  input  wire logic [1:0]  enable_level,
  input  wire logic        step_decreasing,
  input  wire logic        winding_dir,
  input  wire logic        trip_reached,
  input  wire logic        valley_reached,
  input  wire logic        current_zero,
  input  wire logic        motor_undervoltage,
  input  wire logic        other_fault,
  input  wire logic        fault_flag_n_in,
  output logic             fault_flag_n_out,
  output logic             fault_flag_n_oe_n,
  output logic      [3:0]  gate_ctrl,
  output logic             charge_pump_en,
  output logic      [1:0]  ripple_select
);

  typedef struct packed {
    fsm_t        fsm;
    logic [11:0] cnt;
    logic [11:0] fast_len;
    logic [3:0]  share;
    logic        zero_hit;
    logic [3:0]  gates;
    logic        cp_en;
    logic        fault_oe_n;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [1:0]  ctrl;
  } st_t;

  st_t r_reg;
  st_t r_next;

  logic [3:0]  decay_f;
  logic [1:0]  off_time_select_f;

  // ==========================================================
  // Configuration deglitch
  config_deglitch #(.W(4)) u_decay_dg (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .sample ({decay_select_high, decay_select_low}),
    .stable (decay_f)
  );

  config_deglitch #(.W(2)) u_off_time_select_dg (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .sample (off_time_select),
    .stable (off_time_select_f)
  );

  // Three-level pins cannot show a resistor level
  function automatic logic [1:0] tri_level(input logic [1:0] lvl);
    tri_level = (lvl == LVL_RES) ? LVL_OPEN : lvl;
  endfunction

  // ==========================================================
  // Mode and interval decode
  decay_mode_t mode;
  logic [11:0] off_len;
  logic [1:0]  dlow;

  always_comb
  begin
    dlow = tri_level(decay_f[1:0]);
    if (decay_f[3:2] == LVL_OPEN || decay_f[3:2] == LVL_RES)
      mode = DM_DYNAMIC;
    else if (dlow == LVL_LOW)
      mode = decay_f[2] ? DM_RIPPLE : DM_DYNAMIC;
    else if (dlow == LVL_HIGH)
      mode = decay_f[2] ? DM_SLOWMIX : DM_MIX30;
    else
      mode = decay_f[2] ? DM_SLOW : DM_MIX60;
  end

  always_comb
  begin
    case (off_time_select_f)
      LVL_LOW:  off_len = OFF_7_CYC;
      LVL_HIGH: off_len = OFF_16_CYC;
      LVL_OPEN: off_len = OFF_24_CYC;
      default:  off_len = OFF_32_CYC;
    endcase
  end

  // ==========================================================
  // Status word
  logic [31:0] status_word;

  assign status_word = {12'h000, fault_flag_n_in, motor_undervoltage,
                        tri_level(enable_level), microstep_select_1,
                        tri_level(microstep_select_0), off_time_select_f,
                        r_reg.share, mode, r_reg.fsm};

  // ==========================================================
  // Main next-state logic
  logic        run;
  logic        decreasing;
  logic [3:0]  share_v;
  logic [15:0] prod;
  logic [11:0] mix30;
  logic [11:0] mix60;
  logic [11:0] fl;
  logic [3:0]  drv_pat;
  logic [3:0]  fst_pat;

  always_comb
  begin
    r_next     = r_reg;
    run        = sleep_control_n && !motor_undervoltage &&
                 r_reg.ctrl[CTRL_RUN] &&
                 tri_level(enable_level) != LVL_LOW;
    decreasing = step_decreasing || r_reg.ctrl[CTRL_FULL];
    mix30      = 12'((16'(off_len) * MIX30_NUM) / MIX_DEN);
    mix60      = 12'((16'(off_len) * MIX60_NUM) / MIX_DEN);
    share_v    = r_reg.share;
    if (r_reg.cnt >= off_len && share_v != 4'h0)
      share_v  = share_v - 4'h1;
    prod       = 16'(off_len) * 16'(share_v);
    fl         = 12'h000;
    drv_pat    = winding_dir ? GATES_FWD : GATES_REV;
    fst_pat    = winding_dir ? GATES_REV : GATES_FWD;

    // One wait state: answer registered in the first access cycle
    r_next.pready  = 1'b0;
    r_next.pslverr = 1'b0;
    if (psel && penable && !r_reg.pready)
    begin
      r_next.pready = 1'b1;
      case (paddr)
        ADDR_CTRL:   r_next.prdata = {30'h0, r_reg.ctrl};
        ADDR_STATUS: r_next.prdata = status_word;
        default:
        begin
          r_next.prdata  = 32'h0000_0000;
          r_next.pslverr = 1'b1;
        end
      endcase
    end
    if (psel && penable && r_reg.pready && pwrite &&
        paddr == ADDR_CTRL)
      r_next.ctrl = pwdata[1:0];

    r_next.cp_en      = sleep_control_n && !motor_undervoltage;
    r_next.fault_oe_n = !(motor_undervoltage || other_fault);

    if (!sleep_control_n)
    begin
      r_next.fsm      = ST_IDLE;
      r_next.cnt      = 12'h000;
      r_next.share    = 4'h0;
      r_next.fast_len = 12'h000;
      r_next.zero_hit = 1'b0;
    end
    else if (!run)
    begin
      r_next.fsm = ST_IDLE;
      r_next.cnt = 12'h000;
    end
    else
    begin
      case (r_reg.fsm)
        ST_IDLE:
        begin
          r_next.fsm = ST_BLANK;
          r_next.cnt = 12'h000;
        end
        ST_BLANK:
        begin
          // Comparator not looked at until blanking ends
          r_next.cnt = r_reg.cnt + 12'h001;
          if (r_reg.cnt == BLANK_CYC - 12'h001)
          begin
            r_next.fsm = ST_DRIVE;
            if (mode == DM_DYNAMIC && trip_reached &&
                r_reg.share < SHARE_MAX)
              r_next.share = r_reg.share + 4'h1;
          end
        end
        ST_DRIVE:
        begin
          if (r_reg.cnt != 12'hFFF)
            r_next.cnt = r_reg.cnt + 12'h001;
          if (trip_reached)
          begin
            case (mode)
              DM_MIX30:   fl = mix30;
              DM_MIX60:   fl = mix60;
              DM_SLOWMIX: fl = decreasing ? mix30 : 12'h000;
              DM_DYNAMIC:
              begin
                r_next.share = share_v;
                fl = decreasing ? off_len : prod[14:3];
              end
              default:    fl = 12'h000;
            endcase
            r_next.fast_len = fl;
            r_next.zero_hit = 1'b0;
            r_next.cnt      = 12'h000;
            r_next.fsm      = (fl != 12'h000) ? ST_FAST : ST_SLOW;
          end
        end
        ST_FAST:
        begin
          r_next.cnt = r_reg.cnt + 12'h001;
          // Bridge released once winding current is gone
          if (current_zero)
            r_next.zero_hit = 1'b1;
          if (r_reg.cnt + 12'h001 >= off_len)
          begin
            r_next.fsm = ST_BLANK;
            r_next.cnt = 12'h000;
          end
          else if (r_reg.cnt + 12'h001 >= r_reg.fast_len)
            r_next.fsm = ST_SLOW;
        end
        ST_SLOW:
        begin
          r_next.cnt = r_reg.cnt + 12'h001;
          if (mode == DM_RIPPLE)
          begin
            if (valley_reached)
            begin
              r_next.fsm = ST_BLANK;
              r_next.cnt = 12'h000;
            end
          end
          else if (r_reg.cnt + 12'h001 >= off_len)
          begin
            r_next.fsm = ST_BLANK;
            r_next.cnt = 12'h000;
          end
        end
        default:
        begin
          r_next.fsm = ST_IDLE;
          r_next.cnt = 12'h000;
        end
      endcase
    end

    case (r_next.fsm)
      ST_BLANK, ST_DRIVE: r_next.gates = drv_pat;
      ST_FAST:  r_next.gates = r_next.zero_hit ? GATES_OFF : fst_pat;
      ST_SLOW:  r_next.gates = GATES_SLOW;
      default:  r_next.gates = GATES_OFF;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_reg            <= '0;
      r_reg.fault_oe_n <= 1'b1;
      r_reg.ctrl       <= CTRL_RESET;
    end
    else
      r_reg <= r_next;
  end

  // ==========================================================
  // Outputs, all registered except fault_flag_n_out, which is tied low
  assign prdata            = r_reg.prdata;
  assign pready            = r_reg.pready;
  assign pslverr           = r_reg.pslverr;
  assign gate_ctrl         = r_reg.gates;
  assign charge_pump_en    = r_reg.cp_en;
  assign fault_flag_n_oe_n = r_reg.fault_oe_n;
  assign fault_flag_n_out  = 1'b0;
  assign ripple_select     = off_time_select_f;

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  logic on_ok;
  assign on_ok = sleep_control_n && !motor_undervoltage &&
                 r_reg.ctrl[CTRL_RUN] && enable_level != LVL_LOW;

  sequence s_trip_taken;
    r_reg.fsm == ST_DRIVE && trip_reached && on_ok;
  endsequence

  AST_BLANK_MIN: assert property (
    r_reg.fsm == ST_DRIVE && $past(r_reg.fsm) == ST_BLANK |->
      $past(r_reg.cnt) == BLANK_CYC - 12'h001)
    else $error("blanking ended early");

  AST_DRIVE_GATES: assert property (
    $rose(r_reg.fsm == ST_BLANK) && on_ok |->
      (gate_ctrl == GATES_FWD || gate_ctrl == GATES_REV)[*8])
    else $error("drive phase cut short");

  AST_SLOW_LOWSIDE: assert property (
    r_reg.fsm == ST_SLOW |-> gate_ctrl == GATES_SLOW)
    else $error("slow decay without both low sides");

  AST_UV_OFF: assert property (
    motor_undervoltage |=>
      gate_ctrl == GATES_OFF && !charge_pump_en && !fault_flag_n_oe_n)
    else $error("undervoltage did not shut down");

  AST_UV_RECOVER: assert property (
    !motor_undervoltage && !other_fault && sleep_control_n |=>
      fault_flag_n_oe_n && charge_pump_en)
    else $error("fault not released after undervoltage");

  AST_SLOWMIX_RISE: assert property (
    s_trip_taken ##0 (mode == DM_SLOWMIX && !decreasing) |=>
      r_reg.fsm == ST_SLOW)
    else $error("slow-mixed used fast decay on rising step");

  AST_MIXED_FIRST: assert property (
    s_trip_taken ##0 (mode == DM_MIX30 || mode == DM_MIX60) |=>
      r_reg.fsm == ST_FAST ##1 r_reg.fsm == ST_FAST)
    else $error("mixed decay did not start fast");

  AST_DYN_FALL: assert property (
    s_trip_taken ##0 (mode == DM_DYNAMIC && decreasing) |=>
      r_reg.fsm == ST_FAST && r_reg.fast_len == off_len)
    else $error("adaptive falling step not full fast");

  AST_RIPPLE_HOLD: assert property (
    r_reg.fsm == ST_SLOW && mode == DM_RIPPLE && !valley_reached &&
      on_ok |=> r_reg.fsm == ST_SLOW)
    else $error("ripple slow decay left before valley");

  AST_OFF_EXPIRE: assert property (
    r_reg.fsm == ST_SLOW && mode != DM_RIPPLE && on_ok &&
      r_reg.cnt == off_len - 12'h001 |=> r_reg.fsm == ST_BLANK)
    else $error("off interval expiry did not restart drive");

  AST_SLEEP_CLEAR: assert property (
    !sleep_control_n |=> r_reg.fsm == ST_IDLE && r_reg.share == 4'h0)
    else $error("sleep did not clear decay state");

endmodule // chopper_decay_control
`default_nettype wire

// file: dv/winding_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Winding current model for one bridge
module winding_model
  import chopper_pkg::*;
#(
  parameter int TRIP = 2000,
  parameter int GAP  = 300
)
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [3:0] gate_ctrl,
  input  wire logic       winding_dir,
  input  wire logic [7:0] rise,
  output logic            trip_reached,
  output logic            valley_reached,
  output logic            current_zero
);
  int cur;
  // Reversed drive bleeds twice as fast as recirculation
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      cur <= 0;
    else if (gate_ctrl == (winding_dir ? GATES_FWD : GATES_REV))
      cur <= cur + int'(rise);
    else if (gate_ctrl == GATES_SLOW)
      cur <= (cur > 0) ? cur - 1 : 0;
    else if (gate_ctrl != GATES_OFF)
      cur <= (cur > 1) ? cur - 2 : 0;
  assign trip_reached   = cur >= TRIP;
  assign valley_reached = cur <= TRIP - GAP;
  assign current_zero   = cur == 0;
endmodule // winding_model
`default_nettype wire

// file: dv/chopper_decay_control_bench.sv
`timescale 1ns/1ns
`default_nettype none
module chopper_decay_control_bench
  import chopper_pkg::*;
;
  localparam int O7 = int'(OFF_7_CYC);
  localparam int OFFC[4] = '{O7, int'(OFF_16_CYC), int'(OFF_24_CYC),
                             int'(OFF_32_CYC)};
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        sleep_n = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic        pready, pslverr, rerr;
  logic [1:0]  dlo = LVL_LOW, dhi = LVL_LOW, offs = LVL_LOW;
  logic [1:0]  ms0 = LVL_LOW, ms1 = LVL_LOW, en = LVL_HIGH, rsel;
  logic        dec = 1'b0, uv = 1'b0, ofl = 1'b0, dir = 1'b1;
  logic [7:0]  rise = 8'h0A;
  logic        trip, valley, czero, f_out, f_oe_n, pump;
  wire logic   f_pin;
  logic [3:0]  gate_ctrl;
  logic [2:0]  md = DM_DYNAMIC;
  logic [1:0]  ol = LVL_LOW;
  int          failures = 0, n_compared = 0;
  logic [1:0]  tlo[6] = '{LVL_HIGH, LVL_HIGH, LVL_OPEN, LVL_OPEN,
                          LVL_HIGH, LVL_HIGH};
  logic [1:0]  thi[6] = '{LVL_LOW, LVL_LOW, LVL_LOW, LVL_HIGH,
                          LVL_HIGH, LVL_HIGH};
  logic        tdc[6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  logic [3:0]  tg[6] = '{GATES_REV, GATES_REV, GATES_REV, GATES_SLOW,
                         GATES_REV, GATES_SLOW};
  int          tl[6] = '{O7 * 3 / 10, O7 * 3 / 10, O7 * 6 / 10, O7,
                         O7 * 3 / 10, O7};

  // Fault line has a pull-up
  assign f_pin = f_oe_n ? 1'b1 : f_out;
  initial forever #4 mclk = ~mclk;

  chopper_decay_control dut (
    .mclk(mclk), .rst_n(rst_n), .sleep_control_n(sleep_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .decay_select_low(dlo), .decay_select_high(dhi),
    .off_time_select(offs), .microstep_select_0(ms0),
    .microstep_select_1(ms1), .enable_level(en),
    .step_decreasing(dec), .winding_dir(dir), .trip_reached(trip),
    .valley_reached(valley), .current_zero(czero),
    .motor_undervoltage(uv), .other_fault(ofl),
    .fault_flag_n_in(f_pin), .fault_flag_n_out(f_out),
    .fault_flag_n_oe_n(f_oe_n), .gate_ctrl(gate_ctrl),
    .charge_pump_en(pump), .ripple_select(rsel));

  winding_model wm (
    .mclk(mclk), .rst_n(rst_n), .gate_ctrl(gate_ctrl),
    .winding_dir(dir), .rise(rise), .trip_reached(trip),
    .valley_reached(valley), .current_zero(czero));

  // ==========================================================
  // Shared helpers
  task automatic finish_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic hang(string nm);
    failures++;
    $display("Error %s expected done seen timeout", nm);
    finish_test();
  endtask

  // Lengths are judged to one clock either way
  function automatic logic [31:0] near(int n, int e);
    return (n >= e - 1 && n <= e + 1) ? e : n;
  endfunction

  function automatic logic [2:0] emode(logic [1:0] lo, logic [1:0] hi);
    if (hi[1])
      return DM_DYNAMIC;
    if (lo == LVL_LOW)
      return hi[0] ? DM_RIPPLE : DM_DYNAMIC;
    if (lo == LVL_HIGH)
      return hi[0] ? DM_SLOWMIX : DM_MIX30;
    return hi[0] ? DM_SLOW : DM_MIX60;
  endfunction

  task automatic apb(logic w, logic [7:0] a, logic [31:0] wd);
    int i;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge mclk);
      if (pready === 1'b1)
        break;
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 50)
      hang("apb");
  endtask

  // Waits for the gates to enter pattern v
  task automatic wait_gate(logic [3:0] v);
    logic [3:0] p;
    int i;
    p = gate_ctrl;
    for (i = 0; i < 9000; i++)
    begin
      @(posedge mclk);
      if (gate_ctrl === v && p !== v)
        break;
      p = gate_ctrl;
    end
    if (i == 9000)
      hang("gate wait");
  endtask

  task automatic ph(logic [3:0] g, int l);
    int n;
    wait_gate(g);
    n = 0;
    while (gate_ctrl === g && n < 9000)
    begin
      @(posedge mclk);
      n++;
    end
    chk("phase length", near(n, l), l);
  endtask

  task automatic set_mode(logic [1:0] lo, logic [1:0] hi);
    logic [2:0] nm;
    nm = emode(lo, hi);
    dlo <= lo;
    dhi <= hi;
    repeat (1200) @(posedge mclk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("mode held", rdat[5:3], md);
    repeat (100) @(posedge mclk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("mode", rdat[5:3], nm);
    md = nm;
  endtask

  task automatic set_off(logic [1:0] l);
    offs <= l;
    repeat (1200) @(posedge mclk);
    chk("off held", rsel, ol);
    repeat (100) @(posedge mclk);
    chk("ripple select", rsel, l);
    ol = l;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_offtime();
    set_mode(LVL_OPEN, LVL_HIGH);
    for (int k = 1; k < 5; k++)
    begin
      set_off(2'(k));
      ph(GATES_SLOW, OFFC[k % 4]);
      chk("next drive", gate_ctrl, GATES_FWD);
    end
    ph(GATES_FWD, int'(BLANK_CYC) + 1);
  endtask

  task automatic t_modes();
    for (int k = 0; k < 6; k++)
    begin
      dec <= tdc[k];
      set_mode(tlo[k], thi[k]);
      ph(tg[k], tl[k]);
    end
    apb(1'b1, ADDR_CTRL, 32'h3);
    ph(GATES_REV, O7 * 3 / 10);
    apb(1'b1, ADDR_CTRL, 32'h0);
    repeat (3) @(posedge mclk);
    chk("run off", gate_ctrl, GATES_OFF);
    apb(1'b1, ADDR_CTRL, 32'h1);
  endtask

  task automatic t_ripple();
    int i;
    int n;
    set_mode(LVL_LOW, LVL_HIGH);
    wait_gate(GATES_SLOW);
    for (i = 0; i < 9000 && valley !== 1'b1; i++)
      @(posedge mclk);
    for (n = 0; n < 9000 && gate_ctrl === GATES_SLOW; n++)
      @(posedge mclk);
    chk("valley exit", near(n, 1), 1);
  endtask

  task automatic t_adaptive();
    set_mode(LVL_LOW, LVL_LOW);
    sleep_n <= 1'b0;
    repeat (4) @(posedge mclk);
    chk("sleep gates", gate_ctrl, GATES_OFF);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("sleep state", rdat[9:0], 10'h000);
    sleep_n <= 1'b1;
    // Steep rise overshoots at every blank end: one eighth more each cycle
    rise <= 8'h28;
    for (int k = 0; k < 3; k++)
      ph(GATES_REV, OFFC[0] * (k + 1) / 8);
  endtask

  task automatic t_faults();
    uv <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("uv gates", gate_ctrl, GATES_OFF);
    chk("uv pump", pump, 1'b0);
    chk("uv fault", f_oe_n, 1'b0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("uv status", rdat[19:18], 2'b01);
    uv <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("uv clear", {pump, f_oe_n}, 2'b11);
    wait_gate(GATES_FWD);
    ofl <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("fault", f_oe_n, 1'b0);
    ofl <= 1'b0;
    ms0 <= LVL_RES;
    ms1 <= LVL_RES;
    en <= LVL_RES;
    repeat (1300) @(posedge mclk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("levels", rdat[17:12], {LVL_OPEN, LVL_RES, LVL_OPEN});
    en <= LVL_LOW;
    repeat (1300) @(posedge mclk);
    chk("enable low", gate_ctrl, GATES_OFF);
  endtask

  initial
  begin
    repeat (6) @(posedge mclk);
    chk("reset fault", f_oe_n, 1'b1);
    chk("reset gates", gate_ctrl, GATES_OFF);
    rst_n <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl reset", rdat, 32'h1);
    apb(1'b0, 8'h0C, 32'h0);
    chk("unmapped", {rerr, rdat[30:0]}, 32'h80000000);
    t_offtime();
    t_modes();
    t_ripple();
    t_adaptive();
    t_faults();
    finish_test();
  end
endmodule // chopper_decay_control_bench
`default_nettype wire
